// [logic/crm_pkg.sv]
// Constants and types shared by the configuration readback CRC monitor
package crm_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_MHZ       = 1000 / CLK_PERIOD_NS;

  // Register word addresses
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_RATE   = 3'h1;
  localparam logic [2:0] ADDR_REF    = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_CRC    = 3'h4;

  // Control fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_ACT_LSB = 1;
  localparam int CTRL_ACT_MSB = 2;
  localparam int CTRL_PIN_BIT = 3;
  localparam int CTRL_SRC_BIT = 4;
  localparam int RATE_IDX_MSB = 3;

  // Status fields
  localparam int STAT_ERR_BIT  = 0;
  localparam int STAT_RUN_BIT  = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_REFV_BIT = 3;
  localparam int STAT_RSV_BIT  = 4;
  localparam int STAT_PIN_BIT  = 5;

  // Mismatch actions
  localparam logic [1:0] ACT_HALT       = 2'h0;
  localparam logic [1:0] ACT_CONTINUE   = 2'h1;
  localparam logic [1:0] ACT_FIX_RESUME = 2'h2;
  localparam logic [1:0] ACT_FIX_STOP   = 2'h3;

  // Reference source
  localparam logic SRC_PRECOMPUTED = 1'b0;
  localparam logic SRC_FIRST_PASS  = 1'b1;

  // Device variants
  localparam logic VARIANT_A = 1'b0;
  localparam logic VARIANT_B = 1'b1;

  // Reset values
  localparam logic       EN_DEFAULT       = 1'b0;
  localparam logic       PIN_FLAG_DEFAULT = 1'b1;
  localparam logic [3:0] RATE_IDX_DEFAULT = 4'h0;
  localparam logic [31:0] REF_DEFAULT     = 32'h0000_0000;

  // Rate steps in MHz, index 0 is the 1 MHz default
  localparam logic [3:0] RATE_COUNT_A = 4'hd;
  localparam logic [3:0] RATE_COUNT_B = 4'h7;
  localparam logic [12:0][7:0] RATE_STEPS_A = {8'h42, 8'h32, 8'h28, 8'h21, 8'h1a, 8'h16, 8'h10,
                                               8'h0c, 8'h0a, 8'h06, 8'h04, 8'h02, 8'h01};
  localparam logic [6:0][7:0]  RATE_STEPS_B = {8'h32, 8'h19, 8'h0d, 8'h06, 8'h03, 8'h02, 8'h01};

  // Configuration memory and CRC
  localparam int          MEM_AW    = 6;
  localparam logic [5:0]  MEM_LAST  = 6'h3f;
  localparam logic [31:0] CRC_POLY  = 32'h04c1_1db7;
  localparam logic [31:0] CRC_INIT  = 32'hffff_ffff;

  // Checker states
  typedef enum logic [5:0] {
    CRM_IDLE  = 6'h01,
    CRM_SCAN  = 6'h02,
    CRM_FOLD  = 6'h04,
    CRM_CHECK = 6'h08,
    CRM_FIX   = 6'h10,
    CRM_HALT  = 6'h20
  } crm_state_type;

endpackage

// [logic/crm_monitor.sv]
// Configuration readback CRC monitor with Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module crm_monitor
  import crm_pkg::*;
#(
  parameter logic VARIANT = VARIANT_A
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [2:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   mem_rd_en,
  output logic      [MEM_AW-1:0] mem_rd_addr,
  input  wire logic [31:0]       mem_rd_data,
  output logic                   fix_req,
  input  wire logic              fix_done,
  output logic                   upset_error,
  input  wire logic              status_pin_i,
  output logic                   status_pin_o,
  output logic                   status_pin_oe,
  output logic                   pin_user_free
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    crm_state_type     state;
    logic              en;
    logic [1:0]        action;
    logic              pin_flag;
    logic              source;
    logic [3:0]        rate_idx;
    logic [31:0]       ref_crc;
    logic              ref_valid;
    logic              err;
    logic [31:0]       crc;
    logic [31:0]       last_crc;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        div_cnt;
    logic              ack;
    logic [31:0]       rdata;
    logic              rd_en;
    logic              pin_s1;
    logic              pin_s2;
    logic              pin_oe;
  } crm_regs_type;

  // Variant decides the default action
  localparam logic [1:0] ACT_DEFAULT = (VARIANT == VARIANT_A) ? ACT_HALT : ACT_CONTINUE;

  localparam crm_regs_type REGS_RESET = '{
    state:     CRM_IDLE,
    en:        EN_DEFAULT,
    action:    ACT_DEFAULT,
    pin_flag:  PIN_FLAG_DEFAULT,
    source:    SRC_PRECOMPUTED,
    rate_idx:  RATE_IDX_DEFAULT,
    ref_crc:   REF_DEFAULT,
    ref_valid: 1'b0,
    err:       1'b0,
    crc:       CRC_INIT,
    last_crc:  CRC_INIT,
    addr:      '0,
    div_cnt:   8'h00,
    ack:       1'b0,
    rdata:     32'h0000_0000,
    rd_en:     1'b0,
    pin_s1:    1'b0,
    pin_s2:    1'b0,
    pin_oe:    1'b0
  };

  crm_regs_type r_reg;
  crm_regs_type r_next;
  logic         tick;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // CRC-32 folded over one word, msb first
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] v;
    logic        fb;
    v = c;
    for (int i = 31; i >= 0; i--) begin
      fb = v[31] ^ d[i];
      v  = {v[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
    end
    return v;
  endfunction

  // Only listed steps are legal
  function automatic logic rate_ok(input logic [3:0] idx);
    return (VARIANT == VARIANT_A) ? (idx < RATE_COUNT_A) : (idx < RATE_COUNT_B);
  endfunction

  // System cycles per readback word, rounded up; rates above clk_sys get a count of one
  // Never zero: the slowest step gives the largest count, which fits eight bits
  function automatic logic [7:0] rate_div(input logic [3:0] idx);
    logic [7:0] mhz;
    int         q;
    mhz = 8'h01;
    if (VARIANT == VARIANT_A) begin
      if (idx < RATE_COUNT_A) mhz = RATE_STEPS_A[idx];
    end else begin
      if (idx < RATE_COUNT_B) mhz = RATE_STEPS_B[idx[2:0]];
    end
    q = (CLK_MHZ + int'(mhz) - 1) / int'(mhz);
    return q[7:0];
  endfunction

  // Byte-enable merge
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] be);
    logic [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) v[b*8 +: 8] = w[b*8 +: 8];
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus slave, rate divider and checker sequence
  // Memory data is taken at the edge that ends the read strobe cycle, so the far
  // side must answer within that cycle; the address stands through the whole strobe
  always_comb begin
    logic [31:0] ctrl_w;
    ctrl_w = 32'h0000_0000;
    r_next = r_reg;
    // Status pin through two flops before the status read sees it
    r_next.pin_s1 = status_pin_i;
    r_next.pin_s2 = r_reg.pin_s1;
    r_next.rd_en  = 1'b0;

    // One wait state on every access; the answer then stands for a single cycle
    // and a request held past it starts a fresh access
    r_next.ack = (avs_read | avs_write) & ~r_reg.ack;
    if (r_next.ack) begin
      r_next.rdata = 32'h0000_0000;
      case (avs_address)
        ADDR_CTRL: begin
          r_next.rdata[CTRL_EN_BIT]                  = r_reg.en;
          r_next.rdata[CTRL_ACT_MSB:CTRL_ACT_LSB]    = r_reg.action;
          r_next.rdata[CTRL_PIN_BIT]                 = r_reg.pin_flag;
          r_next.rdata[CTRL_SRC_BIT]                 = r_reg.source;
        end
        ADDR_RATE:   r_next.rdata[RATE_IDX_MSB:0] = r_reg.rate_idx;
        ADDR_REF:    r_next.rdata = r_reg.ref_crc;
        ADDR_STATUS: begin
          r_next.rdata[STAT_ERR_BIT]  = r_reg.err;
          r_next.rdata[STAT_RUN_BIT]  = (r_reg.state != CRM_IDLE) && (r_reg.state != CRM_HALT);
          r_next.rdata[STAT_HALT_BIT] = (r_reg.state == CRM_HALT);
          r_next.rdata[STAT_REFV_BIT] = r_reg.ref_valid;
          r_next.rdata[STAT_RSV_BIT]  = ~pin_user_free;
          r_next.rdata[STAT_PIN_BIT]  = r_reg.pin_s2;
        end
        ADDR_CRC:    r_next.rdata = r_reg.last_crc;
        default:     r_next.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes take effect when waitrequest is low
    if (avs_write && r_reg.ack) begin
      case (avs_address)
        ADDR_CTRL: begin
          ctrl_w = 32'h0000_0000;
          ctrl_w[CTRL_EN_BIT]               = r_reg.en;
          ctrl_w[CTRL_ACT_MSB:CTRL_ACT_LSB] = r_reg.action;
          ctrl_w[CTRL_PIN_BIT]              = r_reg.pin_flag;
          ctrl_w[CTRL_SRC_BIT]              = r_reg.source;
          ctrl_w = be_merge(ctrl_w, avs_writedata, avs_byteenable);
          r_next.en       = ctrl_w[CTRL_EN_BIT];
          r_next.action   = ctrl_w[CTRL_ACT_MSB:CTRL_ACT_LSB];
          r_next.pin_flag = ctrl_w[CTRL_PIN_BIT];
          r_next.source   = ctrl_w[CTRL_SRC_BIT];
        end
        ADDR_RATE: begin
          if (avs_byteenable[0] && rate_ok(avs_writedata[RATE_IDX_MSB:0])) begin
            r_next.rate_idx = avs_writedata[RATE_IDX_MSB:0];
          end
        end
        ADDR_REF: r_next.ref_crc = be_merge(r_reg.ref_crc, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end

    // Readback pacing at the selected rate
    // The divider free-runs outside idle, so the first word of a pass may wait a full
    // period; steps above the system clock fall back to one word every two cycles
    tick = (r_reg.div_cnt == 8'h00);
    if (tick || r_reg.state == CRM_IDLE) begin
      r_next.div_cnt = rate_div(r_reg.rate_idx) - 8'h01;
    end else begin
      r_next.div_cnt = r_reg.div_cnt - 8'h01;
    end

    // Checker sequence
    case (r_reg.state)
      CRM_IDLE: begin
        r_next.crc  = CRC_INIT;
        r_next.addr = '0;
        if (r_reg.en) begin
          r_next.ref_valid = (r_reg.source == SRC_PRECOMPUTED);
          r_next.state     = CRM_SCAN;
        end
      end
      CRM_SCAN: begin
        if (tick) begin
          r_next.rd_en = 1'b1;
          r_next.state = CRM_FOLD;
        end
      end
      CRM_FOLD: begin
        r_next.crc = crc_word(r_reg.crc, mem_rd_data);
        if (r_reg.addr == MEM_LAST) begin
          r_next.state = CRM_CHECK;
        end else begin
          r_next.addr  = r_reg.addr + 1'b1;
          r_next.state = CRM_SCAN;
        end
      end
      CRM_CHECK: begin
        r_next.last_crc = r_reg.crc;
        r_next.crc      = CRC_INIT;
        r_next.addr     = '0;
        r_next.state    = CRM_SCAN;
        // First pass of a first-pass source only captures the reference
        if (!r_reg.ref_valid) begin
          r_next.ref_crc   = r_reg.crc;
          r_next.ref_valid = 1'b1;
        end else if (r_reg.crc != r_reg.ref_crc) begin
          r_next.err = 1'b1;
          case (r_reg.action)
            ACT_HALT:       r_next.state = CRM_HALT;
            ACT_CONTINUE:   r_next.state = CRM_SCAN;
            ACT_FIX_RESUME: r_next.state = CRM_FIX;
            ACT_FIX_STOP:   r_next.state = CRM_FIX;
            default:        r_next.state = CRM_HALT;
          endcase
        end
      end
      // Correction request stands until the far side reports done
      CRM_FIX: begin
        if (fix_done) begin
          r_next.state = (r_reg.action == ACT_FIX_RESUME) ? CRM_SCAN : CRM_HALT;
        end
      end
      CRM_HALT: r_next.state = CRM_HALT;
      default:  r_next.state = CRM_IDLE;
    endcase

    // Clearing the enable stops everything at once
    // The error flag survives the stop so a slow observer still sees it
    if (!r_next.en) begin
      r_next.state = CRM_IDLE;
      r_next.rd_en = 1'b0;
    end

    // Open-drain low on error only while the pin flag is set
    r_next.pin_oe = r_next.err & r_next.pin_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // All state in one register; asynchronous reset loads constants only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus handshake
  assign avs_waitrequest = (avs_read | avs_write) & ~r_reg.ack;
  assign avs_readdata    = r_reg.rdata;

  // Memory readback and correction request
  assign mem_rd_en   = r_reg.rd_en;
  assign mem_rd_addr = r_reg.addr;
  assign fix_req     = (r_reg.state == CRM_FIX);

  // Error site and status pin
  // Open-drain pin: only ever pulled low, the board pull-up gives the idle level
  assign upset_error   = r_reg.err;
  assign status_pin_o  = 1'b0;
  assign status_pin_oe = r_reg.pin_oe;
  assign pin_user_free = (VARIANT == VARIANT_B) & ~r_reg.pin_flag;

endmodule

// [sim/crm_checker.sv]
// Port assertions for the readback monitor
`timescale 1ns/1ps
module crm_checker
  import crm_pkg::*;
#(
  parameter logic VARIANT = VARIANT_A
) (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              mem_rd_en,
  input wire logic [MEM_AW-1:0] mem_rd_addr,
  input wire logic              fix_req,
  input wire logic              fix_done,
  input wire logic              upset_error,
  input wire logic              status_pin_o,
  input wire logic              status_pin_oe,
  input wire logic              pin_user_free
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // Error flag and status pin
  AST_STICKY: assert property (upset_error |=> upset_error)
    else $error("error flag dropped");
  AST_PIN_CAUSE: assert property (status_pin_oe |-> upset_error)
    else $error("pin driven without error");
  AST_PIN_LOW: assert property (status_pin_oe |-> !status_pin_o)
    else $error("pin driven high");
  AST_RESERVED: assert property (VARIANT == VARIANT_B || !pin_user_free)
    else $error("pin released to user");
  ////////////////////////////////////////
  // Readback strobes and correction
  AST_READ_GAP: assert property (mem_rd_en |=> !mem_rd_en)
    else $error("reads too close");
  AST_ADDR_HOLD: assert property (mem_rd_en |-> $stable(mem_rd_addr))
    else $error("address moved");
  AST_FIX_DROP: assert property (fix_req && fix_done |=> !fix_req)
    else $error("fix request held");
  AST_FIX_QUIET: assert property (fix_req |-> !mem_rd_en)
    else $error("read during fix");
  AST_FIX_ERR: assert property ($rose(fix_req) |-> upset_error)
    else $error("fix without error");
endmodule
bind crm_monitor crm_checker #(.VARIANT(VARIANT)) i_chk (.clk_sys(clk_sys), .reset(reset),
  .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .fix_req(fix_req), .fix_done(fix_done),
  .upset_error(upset_error), .status_pin_o(status_pin_o), .status_pin_oe(status_pin_oe),
  .pin_user_free(pin_user_free));

// [sim/crm_cfg_mem_model.sv]
// Configuration memory and correction partner
`timescale 1ns/1ps
module crm_cfg_mem_model
  import crm_pkg::*;
#(
  parameter logic [3:0] FIX_DELAY = 4'h3
) (
  input  wire logic              clk_sys,
  input  wire logic              mem_rd_en,
  input  wire logic [MEM_AW-1:0] mem_rd_addr,
  output logic      [31:0]       mem_rd_data,
  input  wire logic              fix_req,
  output logic                   fix_done,
  input  wire logic              inject
);
  logic        upset_reg = 1'b0;
  logic [3:0]  wait_reg  = 4'h0;
  logic [31:0] junk_reg  = 32'h0;
  initial fix_done = 1'b0;
  // Word answers within the strobe cycle, since the monitor folds at the edge ending it
  assign mem_rd_data = mem_rd_en ? (32'hc0de_0000 ^ ({26'h0, mem_rd_addr} * 32'h0001_0203)
                                    ^ {31'h0, upset_reg && mem_rd_addr == 6'h05}) : junk_reg;
  // Changing junk outside a read
  always @(posedge clk_sys) junk_reg <= ~junk_reg;
  // Flip word 5 on demand, repair it after a slow wait
  always @(posedge clk_sys) begin
    fix_done <= 1'b0;
    if (inject) begin
      upset_reg <= 1'b1;
    end
    if (!fix_req) begin
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
      if (wait_reg == FIX_DELAY) begin
        upset_reg <= 1'b0;
        fix_done  <= 1'b1;
      end
    end
  end
endmodule

// [sim/test_config_readback_crc_monitor.sv]
// Self-checking bench for the readback monitor
`timescale 1ns/1ps
module test_config_readback_crc_monitor
  import crm_pkg::*;
;
  logic        clk_sys, reset, avs_read, avs_write, inject, avs_waitrequest;
  logic        mem_rd_en, fix_req, fix_done, upset_error, status_pin_o, status_pin_oe, pin_user_free;
  logic [2:0]  avs_address;
  logic [5:0]  mem_rd_addr;
  logic [31:0] avs_writedata, avs_readdata, mem_rd_data;
  wire         status_pin_i;
  int          bad_count, checked;
  // Pull-up on the open-drain pin
  assign status_pin_i = status_pin_oe ? status_pin_o : 1'b1;
  always #20 clk_sys = ~clk_sys;
  crm_monitor #(.VARIANT(VARIANT_A)) i_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .fix_req(fix_req), .fix_done(fix_done),
    .upset_error(upset_error), .status_pin_i(status_pin_i), .status_pin_o(status_pin_o),
    .status_pin_oe(status_pin_oe), .pin_user_free(pin_user_free));
  crm_cfg_mem_model i_mem (.clk_sys(clk_sys), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .fix_req(fix_req), .fix_done(fix_done), .inject(inject));
  ////////////////////////////////////////
  task print_verdict();
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task do_reset();
    reset <= 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task wait_reads(input int k);
    int n, c;
    n = 0;
    c = 0;
    while (c < k && n < 5000) begin
      @(posedge clk_sys);
      n++;
      if (mem_rd_en === 1'b1) c++;
    end
    if (c < k) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task wait_err();
    int n;
    n = 0;
    while (upset_error !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (upset_error !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask
  function automatic logic [31:0] crc_all(input logic bad);
    logic [31:0] c, w;
    c = CRC_INIT;
    for (int k = 0; k < 64; k++) begin
      w = 32'hc0de_0000 ^ (k * 32'h0001_0203) ^ {31'h0, bad && k == 5};
      for (int b = 31; b >= 0; b--) c = {c[30:0], 1'b0} ^ ((c[31] ^ w[b]) ? CRC_POLY : 32'h0);
    end
    return c;
  endfunction
  ////////////////////////////////////////
  task t_defaults();
    logic [31:0] q;
    int c;
    do_reset();
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    check(q, {27'h0, 1'b0, 1'b1, ACT_HALT, 1'b0});
    bus(1'b1, ADDR_RATE, 32'hd, q);
    bus(1'b0, ADDR_RATE, 32'h0, q);
    check(q, 32'h0);
    bus(1'b1, ADDR_RATE, 32'hc, q);
    bus(1'b0, ADDR_RATE, 32'h0, q);
    check(q, 32'hc);
    bus(1'b0, 3'h5, 32'h0, q);
    check(q, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'ha, q);
    c = 0;
    repeat (300) begin
      @(posedge clk_sys);
      if (mem_rd_en === 1'b1) c++;
    end
    check(c, 0);
  endtask
  task t_first_pass();
    logic [31:0] q;
    do_reset();
    bus(1'b1, ADDR_RATE, 32'hc, q);
    bus(1'b1, ADDR_CTRL, 32'h19, q);
    wait_reads(192);
    check(upset_error, 1'b0);
    bus(1'b0, ADDR_CRC, 32'h0, q);
    check(q, crc_all(1'b0));
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    check(q[STAT_REFV_BIT], 1'b1);
  endtask
  task t_action(input logic [1:0] act, input logic pin);
    logic [31:0] q;
    int c;
    do_reset();
    bus(1'b1, ADDR_RATE, 32'hc, q);
    bus(1'b1, ADDR_REF, crc_all(1'b0), q);
    inject <= 1'b1;
    @(posedge clk_sys);
    inject <= 1'b0;
    bus(1'b1, ADDR_CTRL, {27'h0, 1'b0, pin, act, 1'b1}, q);
    wait_err();
    check(status_pin_i, !pin);
    check(status_pin_oe, pin);
    check(fix_req, act[1]);
    repeat (20) @(posedge clk_sys);
    c = 0;
    repeat (400) begin
      @(posedge clk_sys);
      if (mem_rd_en === 1'b1) c++;
    end
    check(c != 0, act == ACT_CONTINUE || act == ACT_FIX_RESUME);
    bus(1'b0, ADDR_CRC, 32'h0, q);
    check(q, crc_all(act != ACT_FIX_RESUME));
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    check(q[STAT_PIN_BIT], !pin);
    check(q[STAT_HALT_BIT], act == ACT_HALT || act == ACT_FIX_STOP);
    bus(1'b1, ADDR_CTRL, 32'h0, q);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    check(q[STAT_ERR_BIT], 1'b1);
    check(q[STAT_RSV_BIT], 1'b1);
    check(upset_error, 1'b1);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    clk_sys       = 1'b0;
    reset         = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 3'h0;
    avs_writedata = 32'h0;
    inject        = 1'b0;
    bad_count     = 0;
    checked       = 0;
    t_defaults();
    t_first_pass();
    for (int a = 0; a < 4; a++) t_action(a[1:0], 1'b1);
    t_action(ACT_CONTINUE, 1'b0);
    print_verdict();
  end
endmodule
